// >>> rtl/acd_block_config.sv
// Notes on behaviour
// - Completion flag sets when an operation finishes.
// - Rising completion flag triggers the DMA out transfer.
// - Set completion flag means result bytes are readable.
// - Only software clears completion flag, never hardware.
// - Busy reads one during operation; writes ignored.
// - Clearing enable resets and abandons the operation.
// - Encrypt-select one encrypts, zero decrypts.
// - Key code 00: 16-byte key, 218 cycles.
// - Key code 01: 24-byte key, 274 cycles.
// - Key code 10: 32-byte key, 298 cycles; 11 reserved.
// - Output source: raw, XORed, inverse key; 11 reserved.
// - Input XOR enabled feeds block input XOR xor input.
// - Input XOR disabled passes block input unmodified.
// - Block configuration at 0xE9, page 0x2.
// - Data configuration at 0xEA; upper bits read zero.
// - Result read one byte per read, sixteen bytes.
`timescale 1ns/1ns
module acd_block_config
  import acd_pkg::*;
#(
  parameter int BLOCK_BYTES = 16
)
(
  input  wire logic            ref_clk_i,
  input  wire logic            rst_n_i,
  input  acd_pkg::acd_sfr_req_t sfr_req_i,
  output logic [7:0]           sfr_rdata_o,
  output logic                 sfr_rvalid_o,
  output acd_pkg::acd_core_req_t core_req_o,
  output logic [7:0]           core_key_byte_o,
  output logic                 core_key_strobe_o,
  input  wire logic [127:0]    core_result_i,
  input  wire logic [127:0]    core_inv_key_i,
  output logic                 dma_out_trigger_o,
  output logic                 done_o
);
  import acd_pkg::*;

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  // The cipher core data path is fixed at one 128-bit block.
  if (BLOCK_BYTES != 16)
  begin : g_bad_block
    $error("acd_block_config: BLOCK_BYTES must be 16");
  end

  localparam int IDX_W = $clog2(BLOCK_BYTES);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(BLOCK_BYTES - 1);
  localparam logic [IDX_W-1:0] IDX_ONE  = IDX_W'(1);

  // ****************************************************************
  // Register bus decode
  // ****************************************************************
  function automatic logic hit(input acd_sfr_req_t r,
                               input logic [7:0] a);
    return (r.page == SFR_PAGE_CIPHER) && (r.addr == a);
  endfunction : hit

  wire logic wr_bcfg;
  wire logic wr_dcfg;
  wire logic wr_bin;
  wire logic wr_xin;
  wire logic wr_kin;
  wire logic rd_any;
  wire logic rd_yout;

  assign wr_bcfg = sfr_req_i.wr && hit(sfr_req_i, ADDR_BLOCK_CONFIG);
  assign wr_dcfg = sfr_req_i.wr && hit(sfr_req_i, ADDR_DATA_PATH_CFG);
  assign wr_bin  = sfr_req_i.wr && hit(sfr_req_i, ADDR_BLOCK_INPUT);
  assign wr_xin  = sfr_req_i.wr && hit(sfr_req_i, ADDR_XOR_INPUT);
  assign wr_kin  = sfr_req_i.wr && hit(sfr_req_i, ADDR_KEY_INPUT);
  assign rd_any  = sfr_req_i.rd && (sfr_req_i.page == SFR_PAGE_CIPHER);
  assign rd_yout = sfr_req_i.rd && hit(sfr_req_i, ADDR_RESULT_OUTPUT);

  // ****************************************************************
  // Configuration state
  // ****************************************************************
  logic             en_reg;
  logic             enc_reg;
  acd_key_len_t     klen_reg;
  logic             done_reg;
  acd_out_sel_t     osel_reg;
  logic             input_xor_enable_reg;
  wire  logic       busy;
  wire  logic       finish;
  wire  logic       abort;
  wire  logic       done_wr_clear;

  // Enable low holds the byte indexes in reset and the sequencer idle.
  assign abort = !en_reg;

  // Software clears completion by writing zero; a finish in the same
  // cycle still sets it, so no completion is ever lost.
  assign done_wr_clear = wr_bcfg && !sfr_req_i.wdata[BCFG_DONE_BIT];

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      en_reg    <= BCFG_RESET[BCFG_EN_BIT];
      enc_reg   <= BCFG_RESET[BCFG_ENC_BIT];
      klen_reg  <= ACD_KEY_16;
      done_reg  <= BCFG_RESET[BCFG_DONE_BIT];
      osel_reg  <= ACD_OUT_RAW;
      input_xor_enable_reg <= DCFG_RESET[DCFG_INPUT_XOR_ENABLE_BIT];
    end
    else
    begin
      if (wr_bcfg)
      begin
        en_reg   <= sfr_req_i.wdata[BCFG_EN_BIT];
        enc_reg  <= sfr_req_i.wdata[BCFG_ENC_BIT];
        klen_reg <= acd_key_len_t'(
                      sfr_req_i.wdata[BCFG_KLEN_MSB:BCFG_KLEN_LSB]);
      end
      if (finish)
        done_reg <= 1'b1;
      else if (done_wr_clear)
        done_reg <= 1'b0;
      if (wr_dcfg)
      begin
        osel_reg  <= acd_out_sel_t'(
                       sfr_req_i.wdata[DCFG_OSEL_MSB:DCFG_OSEL_LSB]);
        input_xor_enable_reg <= sfr_req_i.wdata[DCFG_INPUT_XOR_ENABLE_BIT];
      end
    end
  end

  // ****************************************************************
  // Input byte capture
  // ****************************************************************
  logic [7:0]       bin_mem [BLOCK_BYTES];
  logic [7:0]       xin_mem [BLOCK_BYTES];
  logic [7:0]       bin_last_reg;
  logic [7:0]       xin_last_reg;
  logic [7:0]       kin_last_reg;
  logic [IDX_W-1:0] bin_idx_reg;
  logic [IDX_W-1:0] xin_idx_reg;
  wire  logic       block_full;

  // The sixteenth block input byte launches the block once enabled.
  assign block_full = wr_bin && (bin_idx_reg == IDX_LAST) && en_reg
                      && !busy;

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bin_idx_reg  <= '0;
      xin_idx_reg  <= '0;
      bin_last_reg <= ZERO_BYTE;
      xin_last_reg <= ZERO_BYTE;
      kin_last_reg <= ZERO_BYTE;
    end
    else if (abort)
    begin
      bin_idx_reg <= '0;
      xin_idx_reg <= '0;
    end
    else
    begin
      if (wr_bin)
      begin
        bin_last_reg <= sfr_req_i.wdata;
        bin_idx_reg  <= bin_idx_reg + IDX_ONE;
      end
      if (wr_xin)
      begin
        xin_last_reg <= sfr_req_i.wdata;
        xin_idx_reg  <= xin_idx_reg + IDX_ONE;
      end
      if (wr_kin)
        kin_last_reg <= sfr_req_i.wdata;
    end
  end

  // Byte arrays carry no reset; their contents only matter after writes.
  always_ff @(posedge ref_clk_i)
  begin
    if (wr_bin && en_reg)
      bin_mem[bin_idx_reg] <= sfr_req_i.wdata;
    if (wr_xin && en_reg)
      xin_mem[xin_idx_reg] <= sfr_req_i.wdata;
  end

  // ****************************************************************
  // Cipher core input path
  // ****************************************************************
  logic [127:0] core_in_data;
  logic [7:0]   bin_now [BLOCK_BYTES];

  // The last block byte is still on the bus when the block launches.
  for (genvar gi = 0; gi < BLOCK_BYTES; gi++)
  begin : g_in_xor
    assign bin_now[gi] = (IDX_W'(gi) == IDX_LAST) ? sfr_req_i.wdata
                                                   : bin_mem[gi];
    assign core_in_data[8*gi +: 8] = input_xor_enable_reg
      ? (bin_now[gi] ^ xin_mem[gi])
      : bin_now[gi];
  end

  acd_core_req_t core_req_reg;
  logic [7:0]    key_byte_reg;
  logic          key_strobe_reg;

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      core_req_reg   <= '0;
      key_byte_reg   <= ZERO_BYTE;
      key_strobe_reg <= 1'b0;
    end
    else
    begin
      core_req_reg.start <= block_full;
      key_strobe_reg     <= wr_kin && en_reg;
      if (block_full)
      begin
        core_req_reg.encrypt <= enc_reg;
        core_req_reg.key_len <= klen_reg;
        core_req_reg.data    <= core_in_data;
      end
      if (wr_kin)
        key_byte_reg <= sfr_req_i.wdata;
    end
  end

  assign core_req_o        = core_req_reg;
  assign core_key_byte_o   = key_byte_reg;
  assign core_key_strobe_o = key_strobe_reg;

  // ****************************************************************
  // Operation sequencer
  // ****************************************************************
  acd_op_seq u_seq (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .abort_i   (abort),
    .start_i   (block_full),
    .key_len_i (klen_reg),
    .busy_o    (busy),
    .finish_o  (finish)
  );

  // ****************************************************************
  // Result capture and output
  // ****************************************************************
  logic [127:0]     res_reg;
  logic [127:0]     inv_reg;
  logic [IDX_W-1:0] out_idx_reg;
  logic             dma_trig_reg;
  wire  logic [7:0] res_byte;
  wire  logic [7:0] inv_byte;
  wire  logic [7:0] xor_byte;
  wire  logic [7:0] yout_byte;

  assign res_byte = res_reg[8*out_idx_reg +: 8];
  assign inv_byte = inv_reg[8*out_idx_reg +: 8];
  // Chaining modes write the xor bytes between result reads, so the
  // xor term is taken live rather than frozen at completion.
  assign xor_byte = xin_mem[out_idx_reg];
  assign yout_byte =
    (osel_reg == ACD_OUT_RAW)     ? res_byte :
    (osel_reg == ACD_OUT_XOR)     ? (res_byte ^ xor_byte) :
    (osel_reg == ACD_OUT_INV_KEY) ? inv_byte : ZERO_BYTE;

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      res_reg      <= '0;
      inv_reg      <= '0;
      out_idx_reg  <= '0;
      dma_trig_reg <= 1'b0;
    end
    else
    begin
      dma_trig_reg <= finish && !done_reg;
      if (finish)
      begin
        res_reg     <= core_result_i;
        inv_reg     <= core_inv_key_i;
        out_idx_reg <= '0;
      end
      else if (abort)
        out_idx_reg <= '0;
      else if (rd_yout)
        out_idx_reg <= out_idx_reg + IDX_ONE;
    end
  end

  assign dma_out_trigger_o = dma_trig_reg;
  assign done_o            = done_reg;

  // ****************************************************************
  // Read data
  // ****************************************************************
  wire logic [7:0] bcfg_view;
  wire logic [7:0] dcfg_view;
  wire logic [7:0] rd_mux;
  logic [7:0]      rdata_reg;
  logic            rvalid_reg;

  assign bcfg_view = {2'b00, done_reg, busy, en_reg, enc_reg, klen_reg};
  assign dcfg_view = {5'b00000, osel_reg, input_xor_enable_reg};
  assign rd_mux =
    hit(sfr_req_i, ADDR_BLOCK_CONFIG)  ? bcfg_view :
    hit(sfr_req_i, ADDR_DATA_PATH_CFG) ? dcfg_view :
    hit(sfr_req_i, ADDR_BLOCK_INPUT)   ? bin_last_reg :
    hit(sfr_req_i, ADDR_XOR_INPUT)     ? xin_last_reg :
    hit(sfr_req_i, ADDR_KEY_INPUT)     ? kin_last_reg :
    hit(sfr_req_i, ADDR_RESULT_OUTPUT) ? yout_byte : ZERO_BYTE;

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_reg  <= ZERO_BYTE;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= rd_any;
      if (rd_any)
        rdata_reg <= rd_mux;
    end
  end

  assign sfr_rdata_o  = rdata_reg;
  assign sfr_rvalid_o = rvalid_reg;

endmodule : acd_block_config

// >>> rtl/acd_op_seq.sv
`timescale 1ns/1ns
module acd_op_seq
  import acd_pkg::*;
(
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         abort_i,
  input  wire logic         start_i,
  input  acd_pkg::acd_key_len_t key_len_i,
  output logic              busy_o,
  output logic              finish_o
);
  import acd_pkg::*;

  typedef enum logic [1:0] {
    ACD_SEQ_IDLE = 2'b01,
    ACD_SEQ_RUN  = 2'b10
  } acd_seq_state_t;

  acd_seq_state_t         state_reg;
  acd_seq_state_t         state_next;
  logic [LAT_CNT_W-1:0]   cnt_reg;
  logic [LAT_CNT_W-1:0]   cnt_next;
  wire  logic             cnt_zero;

  assign cnt_zero = (cnt_reg == '0);
  assign busy_o   = (state_reg == ACD_SEQ_RUN);
  assign finish_o = busy_o && cnt_zero && !abort_i;

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ACD_SEQ_IDLE:
      begin
        if (start_i && !abort_i)
        begin
          state_next = ACD_SEQ_RUN;
          cnt_next   = acd_latency_load(key_len_i);
        end
      end
      ACD_SEQ_RUN:
      begin
        if (abort_i || cnt_zero)
          state_next = ACD_SEQ_IDLE;
        else
          cnt_next = cnt_reg - LAT_CNT_W'(1);
      end
      default: state_next = ACD_SEQ_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= ACD_SEQ_IDLE;
      cnt_reg   <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

endmodule : acd_op_seq

// >>> rtl/acd_pkg.sv
package acd_pkg;

  // ****************************************************************
  // Register page and addresses
  // ****************************************************************
  localparam logic [7:0] SFR_PAGE_CIPHER     = 8'h02;
  localparam logic [7:0] ADDR_BLOCK_CONFIG   = 8'hE9;
  localparam logic [7:0] ADDR_DATA_PATH_CFG  = 8'hEA;
  localparam logic [7:0] ADDR_BLOCK_INPUT    = 8'hEB;
  localparam logic [7:0] ADDR_XOR_INPUT      = 8'hEC;
  localparam logic [7:0] ADDR_KEY_INPUT      = 8'hED;
  localparam logic [7:0] ADDR_RESULT_OUTPUT  = 8'hF5;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int BCFG_DONE_BIT   = 5;
  localparam int BCFG_BUSY_BIT   = 4;
  localparam int BCFG_EN_BIT     = 3;
  localparam int BCFG_ENC_BIT    = 2;
  localparam int BCFG_KLEN_MSB   = 1;
  localparam int BCFG_KLEN_LSB   = 0;
  localparam int DCFG_OSEL_MSB   = 2;
  localparam int DCFG_OSEL_LSB   = 1;
  localparam int DCFG_INPUT_XOR_ENABLE_BIT  = 0;
  localparam logic [7:0] BCFG_RESET = 8'h00;
  localparam logic [7:0] DCFG_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;

  // ****************************************************************
  // Key length codes and block latencies in clock cycles
  // ****************************************************************
  typedef enum logic [1:0] {
    ACD_KEY_16 = 2'b00,
    ACD_KEY_24 = 2'b01,
    ACD_KEY_32 = 2'b10,
    ACD_KEY_RSV = 2'b11
  } acd_key_len_t;

  localparam int LAT_KEY_16_CYCLES = 218;
  localparam int LAT_KEY_24_CYCLES = 274;
  localparam int LAT_KEY_32_CYCLES = 298;
  localparam int LAT_CNT_W         = 9;

  typedef enum logic [1:0] {
    ACD_OUT_RAW     = 2'b00,
    ACD_OUT_XOR     = 2'b01,
    ACD_OUT_INV_KEY = 2'b10,
    ACD_OUT_RSV     = 2'b11
  } acd_out_sel_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic         wr;
    logic         rd;
    logic [7:0]   page;
    logic [7:0]   addr;
    logic [7:0]   wdata;
  } acd_sfr_req_t;

  typedef struct packed {
    logic         start;
    logic         encrypt;
    acd_key_len_t key_len;
    logic [127:0] data;
  } acd_core_req_t;

  // Latency of one block for a key length, less one for the counter.
  function automatic logic [LAT_CNT_W-1:0] acd_latency_load(
    input acd_key_len_t klen
  );
    int cyc;
    case (klen)
      ACD_KEY_24: cyc = LAT_KEY_24_CYCLES;
      ACD_KEY_32: cyc = LAT_KEY_32_CYCLES;
      default:    cyc = LAT_KEY_16_CYCLES;
    endcase
    return LAT_CNT_W'(cyc - 1);
  endfunction : acd_latency_load

endpackage : acd_pkg

// >>> tb/acd_block_config_chk.sv
`timescale 1ns/1ns
module acd_block_config_chk
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  input  acd_pkg::acd_sfr_req_t  sfr_req_i,
  input  wire logic [7:0]        sfr_rdata_o,
  input  wire logic              sfr_rvalid_o,
  input  acd_pkg::acd_core_req_t core_req_o,
  input  wire logic              dma_out_trigger_o,
  input  wire logic              done_o
);
  import acd_pkg::*;
  // ****************
  // Helper logic
  // ****************
  logic       rd_page;
  logic       wr_cfg;
  logic [8:0] cyc_reg;
  logic [8:0] lat_w;
  assign rd_page = sfr_req_i.rd && (sfr_req_i.page == SFR_PAGE_CIPHER);
  assign wr_cfg  = sfr_req_i.wr && (sfr_req_i.page == SFR_PAGE_CIPHER)
                   && (sfr_req_i.addr == ADDR_BLOCK_CONFIG);
  // The counter restarts one edge after busy rises, hence the minus one.
  assign lat_w = (core_req_o.key_len == ACD_KEY_24) ?
                 9'(LAT_KEY_24_CYCLES - 1) :
                 (core_req_o.key_len == ACD_KEY_32) ?
                 9'(LAT_KEY_32_CYCLES - 1) : 9'(LAT_KEY_16_CYCLES - 1);
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i) cyc_reg <= 9'h000;
    else if (core_req_o.start) cyc_reg <= 9'h000;
    else if (cyc_reg != 9'h1FF) cyc_reg <= cyc_reg + 9'h001;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ****************
  // Assertions
  // ****************
  a_read_answer: assert property (rd_page |=> sfr_rvalid_o)
    else $error("Read not answered in the next cycle.");
  a_no_spurious: assert property (!rd_page |=> !sfr_rvalid_o)
    else $error("Read valid without a read.");
  a_upper_zero: assert property (sfr_rvalid_o &&
    $past(sfr_req_i.addr) == ADDR_DATA_PATH_CFG |-> sfr_rdata_o[7:3] == 5'h00)
    else $error("Data config upper bits not zero.");
  a_status_bits: assert property (sfr_rvalid_o &&
    $past(sfr_req_i.addr) == ADDR_BLOCK_CONFIG
    |-> sfr_rdata_o[7:6] == 2'h0 && sfr_rdata_o[5] == $past(done_o))
    else $error("Block config status read wrong.");
  a_done_sticky: assert property (done_o &&
    !(wr_cfg && !sfr_req_i.wdata[5]) |=> done_o)
    else $error("Completion flag cleared by hardware.");
  a_trigger_rise: assert property ($rose(done_o)
    |-> dma_out_trigger_o)
    else $error("No transfer trigger after completion.");
  a_trigger_cause: assert property (dma_out_trigger_o
    |-> done_o && !$past(done_o))
    else $error("Transfer trigger without a rising flag.");
  a_op_latency: assert property ($rose(done_o)
    |-> cyc_reg == lat_w)
    else $error("Operation length wrong for key length.");
  a_rdata_hold: assert property (!sfr_req_i.rd
    |=> $stable(sfr_rdata_o))
    else $error("Read data changed without a read.");
endmodule : acd_block_config_chk

bind acd_block_config acd_block_config_chk u_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sfr_req_i(sfr_req_i),
  .sfr_rdata_o(sfr_rdata_o), .sfr_rvalid_o(sfr_rvalid_o),
  .core_req_o(core_req_o), .dma_out_trigger_o(dma_out_trigger_o),
  .done_o(done_o));

// >>> tb/acd_core_model.sv
`timescale 1ns/1ns
module acd_core_model
#(
  parameter logic [127:0] INV_KEY = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0
)
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  input  acd_pkg::acd_core_req_t core_req_i,
  output logic [127:0]           result_o,
  output logic [127:0]           inv_key_o
);
  import acd_pkg::*;
  // ****************
  // Stand-in cipher
  // ****************
  // A fixed byte mask picked by direction; it only has to differ between the two directions.
  assign inv_key_o = INV_KEY;
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i) result_o <= 128'h0;
    else if (core_req_i.start)
      result_o <= core_req_i.data ^
                  {16{core_req_i.encrypt ? 8'h3C : 8'hC3}};
endmodule : acd_core_model

// >>> tb/test_aes_block_config_datapath.sv
`timescale 1ns/1ns
module test_aes_block_config_datapath;
  import acd_pkg::*;
  localparam logic [127:0] INV_KEY = 128'h00112233445566778899AABBCCDDEEFF;
  logic          ref_clk_i = 1'b0;
  logic          rst_n_i = 1'b0;
  acd_sfr_req_t  req = '0;
  acd_core_req_t core_req;
  logic [7:0]    rdata;
  logic          rvalid;
  logic          trig;
  logic [7:0]    kbyte;
  logic          kstrobe;
  logic          done;
  logic [127:0]  result;
  logic [127:0]  inv_key;
  logic [15:0]   lfsr = 16'hDC1E;
  logic [7:0]    bq[$];
  logic [7:0]    xq[$];
  int            failures = 0;
  int            samples_checked = 0;

  always #50 ref_clk_i = ~ref_clk_i;

  acd_block_config DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .sfr_req_i(req), .sfr_rdata_o(rdata), .sfr_rvalid_o(rvalid),
    .core_req_o(core_req), .core_key_byte_o(kbyte),
    .core_key_strobe_o(kstrobe),
    .core_result_i(result), .core_inv_key_i(inv_key),
    .dma_out_trigger_o(trig), .done_o(done));
  acd_core_model #(.INV_KEY(INV_KEY)) u_core (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .core_req_i(core_req), .result_o(result),
    .inv_key_o(inv_key));

  // ****************
  // Bench tasks
  // ****************
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction : rnd

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask : chk

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    req = '{1'b1, 1'b0, SFR_PAGE_CIPHER, a, d};
    @(negedge ref_clk_i);
    req = '0;
  endtask : sfr_wr

  task automatic rd_chk(input string n, input logic [7:0] a,
                        input logic [7:0] e);
    @(negedge ref_clk_i);
    req = '{1'b0, 1'b1, SFR_PAGE_CIPHER, a, 8'h00};
    @(negedge ref_clk_i);
    req = '0;
    chk(n, e, (rvalid === 1'b1) ? rdata : 8'hXX);
  endtask : rd_chk

  task automatic run_op(input logic [1:0] kl, input logic ec,
                        input logic xi, input logic [1:0] os);
    logic [7:0] cfg;
    logic [7:0] d;
    int n;
    cfg = {4'h0, 1'b1, ec, kl};
    bq.delete();
    xq.delete();
    sfr_wr(ADDR_DATA_PATH_CFG, {5'h00, os, xi});
    sfr_wr(ADDR_BLOCK_CONFIG, cfg);
    for (int i = 0; i < 16; i++)
    begin
      xq.push_back(rnd());
      bq.push_back(rnd());
      sfr_wr(ADDR_XOR_INPUT, xq[i]);
      d = rnd();
      sfr_wr(ADDR_KEY_INPUT, d);
      chk("key byte", d, kbyte);
      chk("key strobe", 8'h01, {7'h00, kstrobe});
      sfr_wr(ADDR_BLOCK_INPUT, bq[i]);
    end
    n = 0;
    while (core_req.start !== 1'b1 && n < 4)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    chk("start", 8'h01, {7'h00, core_req.start});
    chk("encrypt", {7'h00, ec}, {7'h00, core_req.encrypt});
    chk("key length", {6'h00, kl}, {6'h00, core_req.key_len});
    for (int i = 0; i < 16; i++)
      chk("core data", xi ? bq[i] ^ xq[i] : bq[i],
          core_req.data[8*i +: 8]);
    rd_chk("busy", ADDR_BLOCK_CONFIG, cfg | 8'h10);
    n = 0;
    while (done !== 1'b1 && n < 400)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    chk("trigger", 8'h01, {7'h00, trig});
    rd_chk("status", ADDR_BLOCK_CONFIG, cfg | 8'h20);
    for (int j = 0; j < 16; j++)
    begin
      d = (xi ? bq[j] ^ xq[j] : bq[j]) ^ (ec ? 8'h3C : 8'hC3);
      d = (os == 2'b01) ? d ^ xq[j] : (os == 2'b10) ? INV_KEY[8*j +: 8] : d;
      rd_chk("result", ADDR_RESULT_OUTPUT, d);
    end
    sfr_wr(ADDR_BLOCK_CONFIG, cfg | 8'h30);
    rd_chk("done kept", ADDR_BLOCK_CONFIG, cfg | 8'h20);
    $display("Operation with key code %0d finished", kl);
  endtask : run_op

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    repeat (6) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    rd_chk("block cfg reset", ADDR_BLOCK_CONFIG, 8'h00);
    rd_chk("data cfg reset", ADDR_DATA_PATH_CFG, 8'h00);
    rd_chk("unmapped", 8'hE8, 8'h00);
    sfr_wr(ADDR_DATA_PATH_CFG, 8'hFF);
    rd_chk("data cfg bits", ADDR_DATA_PATH_CFG, 8'h07);
    sfr_wr(ADDR_BLOCK_CONFIG, 8'hFD);
    rd_chk("block cfg bits", ADDR_BLOCK_CONFIG, 8'h0D);
    sfr_wr(ADDR_BLOCK_CONFIG, 8'h00);
    $display("Register test finished");
    run_op(2'b00, 1'b1, 1'b0, 2'b00);
    run_op(2'b01, 1'b0, 1'b1, 2'b01);
    run_op(2'b10, 1'b1, 1'b1, 2'b10);
    sfr_wr(ADDR_DATA_PATH_CFG, 8'h06);
    rd_chk("reserved out", ADDR_RESULT_OUTPUT, 8'h00);
    sfr_wr(ADDR_BLOCK_CONFIG, 8'h08);
    for (int i = 0; i < 16; i++)
      sfr_wr(ADDR_BLOCK_INPUT, rnd());
    sfr_wr(ADDR_BLOCK_CONFIG, 8'h00);
    rd_chk("abort", ADDR_BLOCK_CONFIG, 8'h00);
    repeat (300) @(negedge ref_clk_i);
    chk("no done", 8'h00, {7'h00, done});
    $display("Abort test finished");
    tally_and_finish();
  end

  initial
  begin
    #(100 * 20000);
    failures++;
    $display("Watchdog expired");
    tally_and_finish();
  end
endmodule : test_aes_block_config_datapath
